// [design/tape_formatter_option_control.sv]
// Functional notes
// - address-one strap: selected while address line low
// - encoding strap: selected while encoding line low
// - density strap: selected while density request high
// - manual disabled: parity, density from controller only
// - remote density disabled: density from panel only
// - remote: density and parity from request lines
// - manual: density and parity from panel switches
// - optional strap forces odd parity on nine-track
// - strap stops rewind raising command busy
// - busy set on rewind, cleared on completion
// - even seven-track read: bcd ten becomes zero
// - bcd ten is bits four and six only
// - even seven-track write: zero becomes bcd ten
// - strap suppresses file-mark parity error
// - strap selects seven-track file mark on nine-track
// - file marks octal 23 normal, octal 17 substitute
// - per-unit single-stack straps or unit reported
// - strap picks narrow or wide head gap
// - pre and post delays position tape in gap
// - halt delay after motion removed
// - delays depend on listed tape factors
`timescale 1ns/1ps
`default_nettype none
module tape_formatter_option_control (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire fmt_option_pkg::straps_type straps_in,
    input wire logic formatter_address_line_n_in,
    input wire logic encoding_select_n_in,
    input wire logic high_density_request_in,
    input wire logic odd_parity_request_in,
    input wire logic manual_mode_in,
    input wire logic operator_panel_density_in,
    input wire logic operator_panel_odd_parity_in,
    input wire logic [3:0] unit_select_in,
    input wire logic [3:0] unit_nine_track_in,
    input wire logic [3:0] unit_single_report_in,
    input wire logic rewind_issue_in,
    input wire logic rewind_complete_in,
    input wire logic [8:0] read_char_in,
    input wire logic [8:0] write_char_in,
    input wire logic fm_parity_error_in,
    input wire logic delay_start_in,
    input wire fmt_option_pkg::delay_kind_type delay_kind_in,
    input wire fmt_option_pkg::delay_factors_type delay_factors_in,
    output logic selected_out,
    output logic high_density_out,
    output logic odd_parity_out,
    output logic single_stack_out,
    output logic command_busy_out,
    output logic [8:0] read_char_out,
    output logic [8:0] write_char_out,
    output logic [7:0] file_mark_code_out,
    output logic parity_error_out,
    output logic delay_busy_out,
    output logic delay_done_out
);
    // two-stage synchronisers for every pin input except the straps and the delay start, kind and factors
    // reset clears them, so active-low pins read as asserted for two edges after reset
    localparam int SYNC_W = 40;
    logic [SYNC_W-1:0] pins_raw;
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] pins_q;

    assign pins_raw = {formatter_address_line_n_in, encoding_select_n_in, high_density_request_in,
                       odd_parity_request_in, manual_mode_in, operator_panel_density_in,
                       operator_panel_odd_parity_in, unit_select_in, unit_nine_track_in,
                       unit_single_report_in, rewind_issue_in, rewind_complete_in,
                       read_char_in, write_char_in, fm_parity_error_in};

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            meta_q <= '0;
            pins_q <= '0;
        end else begin
            meta_q <= pins_raw;
            pins_q <= meta_q;
        end
    end

    logic addr_n_s, enc_n_s, hi_den_s, odd_req_s, manual_s, pan_den_s, pan_odd_s;
    logic [3:0] usel_s, unine_s, urep_s;
    logic rew_s, rew_done_s, fm_perr_s;
    logic [8:0] rd_s, wr_s;
    assign {addr_n_s, enc_n_s, hi_den_s, odd_req_s, manual_s, pan_den_s, pan_odd_s,
            usel_s, unine_s, urep_s, rew_s, rew_done_s, rd_s, wr_s, fm_perr_s} = pins_q;

    // straps are static wiring, taken directly each cycle
    fmt_option_pkg::straps_type st;
    assign st = straps_in;

    logic nine_sel, ss_sel;
    assign nine_sel = |(usel_s & unine_s);
    // unit report replaces per-unit straps when chosen
    assign ss_sel = st.unit_ss_report_strap ? |(usel_s & urep_s) : |(usel_s & st.unit_ss_strap);

    logic sel_d, den_d, odd_d;
    always_comb begin
        // integrator fits at most one; priority only settles illegal combos
        if (st.addr_one_strap) sel_d = !addr_n_s;
        else if (st.encoding_sel_strap) sel_d = !enc_n_s;
        else if (st.density_sel_strap) sel_d = hi_den_s;
        else sel_d = 1'b1;
    end

    always_comb begin
        if (st.manual_disable_strap) begin
            den_d = hi_den_s;
            odd_d = odd_req_s;
        end else begin
            odd_d = manual_s ? pan_odd_s : odd_req_s;
            if (st.remote_density_disable_strap) den_d = pan_den_s;
            else den_d = manual_s ? pan_den_s : hi_den_s;
        end
        if (st.auto_odd_strap && nine_sel) odd_d = 1'b1;
    end

    logic sel_q, den_q, odd_q, ss_q;
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sel_q <= 1'b0;
            den_q <= 1'b0;
            odd_q <= 1'b0;
            ss_q <= 1'b0;
        end else begin
            sel_q <= sel_d;
            den_q <= nine_sel ? 1'b0 : den_d;
            odd_q <= odd_d;
            ss_q <= ss_sel;
        end
    end
    assign selected_out = sel_q;
    assign high_density_out = den_q;
    assign odd_parity_out = odd_q;
    assign single_stack_out = ss_q;

    // command busy: completion of a rewind ends it; a new issue wins a tie
    logic busy_q;
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            busy_q <= 1'b0;
        end else if (rew_s && !st.no_rewind_irq_strap) begin
            busy_q <= 1'b1;
        end else if (rew_done_s) begin
            busy_q <= 1'b0;
        end
    end
    assign command_busy_out = busy_q;

    logic [8:0] rd_c, wr_c;
    char_convert u_conv (
        .seven_even_in(!nine_sel && !odd_d),
        .no_read_conv_in(st.no_read_conv_strap),
        .no_write_conv_in(st.no_write_conv_strap),
        .rd_char_in(rd_s),
        .wr_char_in(wr_s),
        .rd_char_out(rd_c),
        .wr_char_out(wr_c)
    );

    logic [8:0] rd_q, wr_q;
    logic [7:0] fm_q;
    logic perr_q;
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_q <= 9'h000;
            wr_q <= 9'h000;
            fm_q <= fmt_option_pkg::FM_CODE_NORMAL;
            perr_q <= 1'b0;
        end else begin
            rd_q <= rd_c;
            wr_q <= wr_c;
            // a seven-track unit always takes the seven-track mark; the strap extends it to nine-track
            fm_q <= (st.seven_fm_on_nine_strap || !nine_sel) ? fmt_option_pkg::FM_CODE_SEVEN
                                                             : fmt_option_pkg::FM_CODE_NORMAL;
            perr_q <= fm_perr_s && !st.no_fm_parity_err_strap;
        end
    end
    assign read_char_out = rd_q;
    assign write_char_out = wr_q;
    assign file_mark_code_out = fm_q;
    assign parity_error_out = perr_q;

    // start, kind and factors come from logic on this clock, so they skip the synchronisers
    logic dly_busy, dly_done, dly_busy_q, dly_done_q;
    motion_delay u_delay (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .start_in(delay_start_in),
        .kind_in(delay_kind_in),
        .factors_in(delay_factors_in),
        .wide_gap_in(st.wide_gap_strap),
        .busy_out(dly_busy),
        .done_out(dly_done)
    );
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dly_busy_q <= 1'b0;
            dly_done_q <= 1'b0;
        end else begin
            dly_busy_q <= dly_busy;
            dly_done_q <= dly_done;
        end
    end
    assign delay_busy_out = dly_busy_q;
    assign delay_done_out = dly_done_q;

    a_select_none: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        !(st.addr_one_strap | st.encoding_sel_strap | st.density_sel_strap) |=> sel_q)
        else $error("select not forced with no strap");
    a_select_addr: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        st.addr_one_strap |=> sel_q == !$past(addr_n_s))
        else $error("address select wrong");
    a_select_dens: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.addr_one_strap && !st.encoding_sel_strap && st.density_sel_strap) |=> sel_q == $past(hi_den_s))
        else $error("density select wrong");
    a_manual_off: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (st.manual_disable_strap && !(st.auto_odd_strap && nine_sel)) |=> odd_q == $past(odd_req_s))
        else $error("manual disable ignored");
    a_auto_odd: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (st.auto_odd_strap && nine_sel) |=> odd_q)
        else $error("odd parity not forced");
    a_busy_set: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (rew_s && !st.no_rewind_irq_strap) |=> busy_q)
        else $error("busy not set on rewind");
    a_busy_strap: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (st.no_rewind_irq_strap && !busy_q) |=> !busy_q)
        else $error("busy raised despite strap");
    a_read_conv: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!nine_sel && !odd_d && !st.no_read_conv_strap && rd_s == fmt_option_pkg::BCD_TEN_CODE)
        |=> rd_q == fmt_option_pkg::ZERO_CODE)
        else $error("bcd ten not converted");
    a_fm_perr: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        st.no_fm_parity_err_strap |=> !perr_q)
        else $error("file mark parity error not suppressed");

    // mode checks compare with the synchronised pins one edge back; a_nine_density only checks density stays low
    a_select_enc: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.addr_one_strap && st.encoding_sel_strap) |=> sel_q == !$past(enc_n_s))
        else $error("encoding select wrong");
    a_manual_den: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (st.manual_disable_strap && !nine_sel) |=> den_q == $past(hi_den_s))
        else $error("density not from controller");
    a_panel_density: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.manual_disable_strap && st.remote_density_disable_strap && !nine_sel)
        |=> den_q == $past(pan_den_s))
        else $error("density not from panel");
    a_remote_density: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.manual_disable_strap && !st.remote_density_disable_strap && !manual_s && !nine_sel)
        |=> den_q == $past(hi_den_s))
        else $error("remote density wrong");
    a_remote_parity: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.manual_disable_strap && !manual_s && !(st.auto_odd_strap && nine_sel))
        |=> odd_q == $past(odd_req_s))
        else $error("remote parity wrong");
    a_panel_mode: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.manual_disable_strap && manual_s && !nine_sel) |=> den_q == $past(pan_den_s))
        else $error("panel density wrong");
    a_panel_parity: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.manual_disable_strap && manual_s && !(st.auto_odd_strap && nine_sel))
        |=> odd_q == $past(pan_odd_s))
        else $error("panel parity wrong");
    a_nine_density: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        nine_sel |=> !den_q)
        else $error("density raised on nine-track unit");

    // conversion and file-mark checks
    a_write_conv: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!nine_sel && !odd_d && !st.no_write_conv_strap && wr_s == fmt_option_pkg::ZERO_CODE)
        |=> wr_q == fmt_option_pkg::BCD_TEN_CODE)
        else $error("zero not converted");
    a_read_bypass: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        st.no_read_conv_strap |=> rd_q == $past(rd_s))
        else $error("read conversion not disabled");
    a_write_bypass: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        st.no_write_conv_strap |=> wr_q == $past(wr_s))
        else $error("write conversion not disabled");
    a_fm_seven: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (st.seven_fm_on_nine_strap || !nine_sel) |=> fm_q == fmt_option_pkg::FM_CODE_SEVEN)
        else $error("seven-track mark not used");
    a_fm_normal: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.seven_fm_on_nine_strap && nine_sel) |=> fm_q == fmt_option_pkg::FM_CODE_NORMAL)
        else $error("normal mark not used");

    // unit, busy, parity and delay checks
    a_ss_none: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.unit_ss_report_strap && (usel_s & st.unit_ss_strap) == 4'h0) |=> !ss_q)
        else $error("single stack without strap");
    a_ss_report: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (st.unit_ss_report_strap && (usel_s & urep_s) != 4'h0) |=> ss_q)
        else $error("unit single stack report ignored");
    a_busy_clear: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (rew_done_s && (!rew_s || st.no_rewind_irq_strap)) |=> !busy_q)
        else $error("busy not cleared");
    a_busy_hold: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (busy_q && !rew_done_s) |=> busy_q)
        else $error("busy dropped early");
    a_perr_pass: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        (!st.no_fm_parity_err_strap && fm_perr_s) |=> perr_q)
        else $error("file mark parity error lost");
    a_delay_pulse: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        dly_done_q |=> !dly_done_q)
        else $error("delay done too long");
    a_delay_end: assert property (@(posedge mclk_in) disable iff (!nrst_in)
        dly_done_q |-> !dly_busy_q)
        else $error("delay busy with done");
endmodule // tape_formatter_option_control
`default_nettype wire

// [design/fmt_option_pkg.sv]
package fmt_option_pkg;

    // file-mark codes on nine-track units (octal 23, octal 17)
    localparam logic [7:0] FM_CODE_NORMAL = 8'h13;
    localparam logic [7:0] FM_CODE_SEVEN = 8'h0f;
    // bcd ten character, parity in bit 8: ones on data bits four and six
    localparam logic [8:0] BCD_TEN_CODE = 9'h050;
    localparam logic [8:0] ZERO_CODE = 9'h000;

    // clock and delay timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int BASE_DELAY_US = 100;
    localparam int BASE_DELAY_CYC = (BASE_DELAY_US * 1000) / CLK_PERIOD_NS;
    localparam int DELAY_W = 20;
    localparam logic [1:0] BUSY_RESET = 2'h0;

    typedef struct packed {
        logic addr_one_strap;
        logic encoding_sel_strap;
        logic density_sel_strap;
        logic manual_disable_strap;
        logic remote_density_disable_strap;
        logic auto_odd_strap;
        logic no_rewind_irq_strap;
        logic no_read_conv_strap;
        logic no_write_conv_strap;
        logic no_fm_parity_err_strap;
        logic seven_fm_on_nine_strap;
        logic wide_gap_strap;
        logic unit_ss_report_strap;
        logic [3:0] unit_ss_strap;
    } straps_type;

    typedef struct packed {
        logic nine_track;
        logic [1:0] speed_sel;
        logic single_stack;
        logic reverse;
        logic at_bot;
        logic write_cmd;
        logic edit_mode;
    } delay_factors_type;

    typedef enum logic [1:0] {
        DLY_PRE = 2'b00,
        DLY_POST = 2'b01,
        DLY_HALT = 2'b10
    } delay_kind_type;

    typedef enum logic [1:0] {
        TMR_IDLE = 2'b00,
        TMR_RUN = 2'b01,
        TMR_DONE = 2'b10
    } timer_state_type;

endpackage

// [design/char_convert.sv]
`timescale 1ns/1ps
`default_nettype none
module char_convert (
    input wire logic seven_even_in,
    input wire logic no_read_conv_in,
    input wire logic no_write_conv_in,
    input wire logic [8:0] rd_char_in,
    input wire logic [8:0] wr_char_in,
    output logic [8:0] rd_char_out,
    output logic [8:0] wr_char_out
);
    always_comb begin
        rd_char_out = rd_char_in;
        if (seven_even_in && !no_read_conv_in && rd_char_in == fmt_option_pkg::BCD_TEN_CODE) begin
            rd_char_out = fmt_option_pkg::ZERO_CODE;
        end
    end

    always_comb begin
        wr_char_out = wr_char_in;
        if (seven_even_in && !no_write_conv_in && wr_char_in == fmt_option_pkg::ZERO_CODE) begin
            wr_char_out = fmt_option_pkg::BCD_TEN_CODE;
        end
    end
endmodule // char_convert
`default_nettype wire

// [design/motion_delay.sv]
`timescale 1ns/1ps
`default_nettype none
module motion_delay (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic start_in,
    input wire fmt_option_pkg::delay_kind_type kind_in,
    input wire fmt_option_pkg::delay_factors_type factors_in,
    input wire logic wide_gap_in,
    output logic busy_out,
    output logic done_out
);
    localparam logic [19:0] BASE = 20'(fmt_option_pkg::BASE_DELAY_CYC);

    // weights are relative; absolute lengths scale with BASE
    function automatic logic [19:0] delay_len(input fmt_option_pkg::delay_kind_type k,
                                              input fmt_option_pkg::delay_factors_type f,
                                              input logic wide);
        logic [19:0] n;
        n = BASE;
        if (k == fmt_option_pkg::DLY_HALT) n = BASE >> 1;
        if (f.write_cmd && k != fmt_option_pkg::DLY_POST) n = n + (BASE >> 2);
        if (wide) n = n + (BASE >> 2);
        if (f.single_stack) n = n + (BASE >> 3);
        if (!f.nine_track) n = n + (BASE >> 3);
        if (f.reverse) n = n + (BASE >> 3);
        if (f.at_bot) n = n + BASE;
        if (f.edit_mode) n = n - (BASE >> 3);
        n = n >> f.speed_sel;
        if (n == 20'h00000) n = 20'h00001;
        return n;
    endfunction

    fmt_option_pkg::timer_state_type state_q;
    logic [19:0] count_q;

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            state_q <= fmt_option_pkg::TMR_IDLE;
            count_q <= 20'h00000;
        end else begin
            case (state_q)
                fmt_option_pkg::TMR_IDLE: begin
                    if (start_in) begin
                        count_q <= delay_len(kind_in, factors_in, wide_gap_in);
                        state_q <= fmt_option_pkg::TMR_RUN;
                    end
                end
                fmt_option_pkg::TMR_RUN: begin
                    if (count_q == 20'h00001) begin
                        state_q <= fmt_option_pkg::TMR_DONE;
                    end
                    count_q <= count_q - 20'h00001;
                end
                fmt_option_pkg::TMR_DONE: state_q <= fmt_option_pkg::TMR_IDLE;
                default: state_q <= fmt_option_pkg::TMR_IDLE;
            endcase
        end
    end

    assign busy_out = (state_q == fmt_option_pkg::TMR_RUN);
    assign done_out = (state_q == fmt_option_pkg::TMR_DONE);
endmodule // motion_delay
`default_nettype wire

// [tb/host_ctrl_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_ctrl_model (
    input wire logic mclk_in,
    input wire logic [3:0] req_in,
    input wire logic density_off_in,
    output logic formatter_address_line_n_out,
    output logic encoding_select_n_out,
    output logic high_density_request_out,
    output logic odd_parity_request_out
);
    // lines move only on the falling edge, well clear of the formatter's sampling edge
    always @(negedge mclk_in) begin
        formatter_address_line_n_out <= req_in[0];
        encoding_select_n_out <= req_in[1];
        // density request is grounded while density_off_in is set, as with remote density disabled
        high_density_request_out <= req_in[2] & ~density_off_in;
        odd_parity_request_out <= req_in[3];
    end
endmodule // host_ctrl_model
`default_nettype wire

// [tb/tape_formatter_option_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin error_cnt++; $display("ERROR %0t: got %0h expected %0h", $time, got, exp); end end
module tape_formatter_option_control_tb;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    fmt_option_pkg::straps_type straps = '0;
    logic [3:0] req = 4'h3;
    logic density_off = 1'b0;
    logic addr_n, enc_n, hd_req, odd_req;
    logic manual = 1'b0, pnl_den = 1'b0, pnl_odd = 1'b0;
    logic [3:0] unit_sel = 4'h1, unit_nine = 4'h0, unit_rep = 4'h0;
    logic rew_issue = 1'b0, rew_done = 1'b0, fm_perr = 1'b0, dstart = 1'b0;
    logic [8:0] rd_char = 9'h000, wr_char = 9'h001;
    fmt_option_pkg::delay_kind_type dkind = fmt_option_pkg::DLY_PRE;
    fmt_option_pkg::delay_factors_type dfac = '0;
    logic sel, hden, oddp, ss, command_busy, perr, dbusy, ddone, panel;
    logic [8:0] rd_out, wr_out;
    logic [7:0] fm_code;
    logic [3:0] v;
    int lens[6];
    int error_cnt = 0;
    int n_compared = 0;

    always #25 mclk_in = ~mclk_in;

    host_ctrl_model u_host (.mclk_in(mclk_in), .req_in(req), .density_off_in(density_off),
        .formatter_address_line_n_out(addr_n), .encoding_select_n_out(enc_n),
        .high_density_request_out(hd_req), .odd_parity_request_out(odd_req));

    tape_formatter_option_control u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .straps_in(straps),
        .formatter_address_line_n_in(addr_n), .encoding_select_n_in(enc_n),
        .high_density_request_in(hd_req), .odd_parity_request_in(odd_req), .manual_mode_in(manual),
        .operator_panel_density_in(pnl_den), .operator_panel_odd_parity_in(pnl_odd),
        .unit_select_in(unit_sel), .unit_nine_track_in(unit_nine), .unit_single_report_in(unit_rep),
        .rewind_issue_in(rew_issue), .rewind_complete_in(rew_done), .read_char_in(rd_char),
        .write_char_in(wr_char), .fm_parity_error_in(fm_perr), .delay_start_in(dstart),
        .delay_kind_in(dkind), .delay_factors_in(dfac), .selected_out(sel), .high_density_out(hden),
        .odd_parity_out(oddp), .single_stack_out(ss), .command_busy_out(command_busy), .read_char_out(rd_out),
        .write_char_out(wr_out), .file_mark_code_out(fm_code), .parity_error_out(perr),
        .delay_busy_out(dbusy), .delay_done_out(ddone));

    // model adds one falling edge, the formatter three rising edges; six cycles covers both
    task automatic settle();
        repeat (6) @(negedge mclk_in);
    endtask

    task automatic test_end(input string name);
        $display("test %s finished, errors so far %0d", name, error_cnt);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk_in);
        s = 1'b0;
        settle();
    endtask

    // one timed delay; a second start mid-count must be ignored
    task automatic run_delay(output int len);
        int n;
        dstart = 1'b1;
        @(negedge mclk_in);
        dstart = 1'b0;
        n = 0;
        while (dbusy !== 1'b1 && n < 8) begin
            @(negedge mclk_in);
            n++;
        end
        `CHK(dbusy, 1'b1)
        if (dbusy !== 1'b1) print_verdict();
        n = 0;
        while (ddone !== 1'b1 && n < 30000) begin
            dstart = (n == 10);
            @(negedge mclk_in);
            n++;
        end
        dstart = 1'b0;
        `CHK(ddone, 1'b1)
        if (n >= 30000) print_verdict();
        len = n;
        @(negedge mclk_in);
        `CHK(ddone, 1'b0)
        repeat (4) @(negedge mclk_in);
        `CHK(dbusy, 1'b0)
    endtask

    initial begin
        repeat (8) @(negedge mclk_in);
        `CHK(fm_code, 8'h13)
        `CHK(command_busy, 1'b0)
        nrst_in = 1'b1;
        settle();
        `CHK(sel, 1'b1)
        straps.addr_one_strap = 1'b1;
        settle();
        `CHK(sel, 1'b0)
        req = 4'h2;
        settle();
        `CHK(sel, 1'b1)
        straps.addr_one_strap = 1'b0;
        straps.encoding_sel_strap = 1'b1;
        settle();
        `CHK(sel, 1'b0)
        req = 4'h1;
        settle();
        `CHK(sel, 1'b1)
        straps.encoding_sel_strap = 1'b0;
        straps.density_sel_strap = 1'b1;
        settle();
        `CHK(sel, 1'b0)
        req = 4'h7;
        settle();
        `CHK(sel, 1'b1)
        straps.density_sel_strap = 1'b0;
        test_end("select");
        // 0 normal, 1 manual disabled, 2 remote density disabled
        for (int c = 0; c < 3; c++) begin
            for (int m = 0; m < 2; m++) begin
                for (int p = 0; p < 2; p++) begin
                    v = p[0] ? 4'b0110 : 4'b1001;
                    straps.manual_disable_strap = (c == 1);
                    straps.remote_density_disable_strap = (c == 2);
                    density_off = (c == 2);
                    manual = m[0];
                    req = {v[2], v[3], 2'b11};
                    pnl_den = v[1];
                    pnl_odd = v[0];
                    settle();
                    panel = m[0] & (c != 1);
                    `CHK(hden, (c == 2 || panel) ? v[1] : v[3])
                    `CHK(oddp, panel ? v[0] : v[2])
                end
            end
        end
        straps = '0;
        density_off = 1'b0;
        manual = 1'b0;
        test_end("density_parity");
        req = 4'h7;
        unit_nine = 4'h1;
        settle();
        `CHK(oddp, 1'b0)
        `CHK(hden, 1'b0)
        `CHK(fm_code, 8'h13)
        straps.auto_odd_strap = 1'b1;
        straps.seven_fm_on_nine_strap = 1'b1;
        settle();
        `CHK(oddp, 1'b1)
        `CHK(fm_code, 8'h0f)
        straps = '0;
        unit_nine = 4'h0;
        test_end("nine_track");
        rd_char = fmt_option_pkg::BCD_TEN_CODE;
        wr_char = fmt_option_pkg::ZERO_CODE;
        settle();
        `CHK(rd_out, 9'h000)
        `CHK(wr_out, 9'h050)
        `CHK(fm_code, 8'h0f)
        rd_char = 9'h040;
        straps.no_write_conv_strap = 1'b1;
        settle();
        `CHK(rd_out, 9'h040)
        `CHK(wr_out, 9'h000)
        rd_char = 9'h050;
        straps.no_read_conv_strap = 1'b1;
        straps.no_write_conv_strap = 1'b0;
        req = 4'hb;
        settle();
        `CHK(rd_out, 9'h050)
        `CHK(wr_out, 9'h000)
        straps = '0;
        req = 4'h3;
        test_end("conversion");
        fm_perr = 1'b1;
        settle();
        `CHK(perr, 1'b1)
        straps.no_fm_parity_err_strap = 1'b1;
        settle();
        `CHK(perr, 1'b0)
        straps.unit_ss_strap = 4'h2;
        unit_sel = 4'h2;
        settle();
        `CHK(ss, 1'b1)
        unit_sel = 4'h1;
        settle();
        `CHK(ss, 1'b0)
        straps.unit_ss_report_strap = 1'b1;
        unit_rep = 4'h1;
        settle();
        `CHK(ss, 1'b1)
        straps = '0;
        test_end("flags");
        pulse(rew_issue);
        `CHK(command_busy, 1'b1)
        pulse(rew_done);
        `CHK(command_busy, 1'b0)
        straps.no_rewind_irq_strap = 1'b1;
        pulse(rew_issue);
        `CHK(command_busy, 1'b0)
        test_end("rewind");
        for (int k = 0; k < 6; k++) begin
            dkind = fmt_option_pkg::delay_kind_type'(k < 3 ? k : 0);
            straps.wide_gap_strap = (k == 3);
            dfac.speed_sel = (k == 4) ? 2'h1 : 2'h0;
            dfac.at_bot = (k == 5);
            dfac.write_cmd = (k == 5);
            run_delay(lens[k]);
        end
        `CHK(lens[3] != lens[0], 1'b1)
        `CHK(lens[4] != lens[0], 1'b1)
        `CHK(lens[5] != lens[0], 1'b1)
        test_end("delays");
        print_verdict();
    end
endmodule // tape_formatter_option_control_tb
`default_nettype wire
